// file: design/vcf_pkg.sv
// Behaviour
// - Coefficients: four terms, balance taps three
// - Transmit gain applies one plus coefficient
// - Term one is most significant binary one
// - Adaptation changes only non-recursive balance taps
// - Continuous adaptation runs until host disables
// - After adapt-and-freeze, coefficients stay unchanged
// - Read-balance command returns current adapted taps
// - Host loads valid balance set before adapting
// - Echo path gain detects talker, suspends adaptation
// - Iterate until error threshold loss is met
// - Time-slot loopback routes receive to transmit
// - Scaling value 10000 loops converters internally
// - Looped signal still drives analog output
// - Analog loopback, high-pass bypass, path cut-offs
// - A-law positive code 128+n, even bits inverted
// - Mu-law positive code 255-n
// - First code bit zero for negative input
// - A-law decoder outputs interval midpoint
// - Chopper clock runs when active, else high
// - Line pins: write outputs, read state
// - Line pin direction follows direction command
// - Output-only fifth pin set output before use
// - Term: sign bit plus three-bit shift code
package vcf_pkg;
   localparam int OP_W = 6;
   localparam int IDX_W = 4;
   localparam int DATA_W = 16;
   // Command numbers on the control port
   localparam logic [5:0] OP_SCALE_WR = 6'h0D;
   localparam logic [5:0] OP_IO_WR = 6'h0F;
   localparam logic [5:0] OP_IO_RD = 6'h10;
   localparam logic [5:0] OP_DIR_WR = 6'h11;
   localparam logic [5:0] OP_ADAPT_WR = 6'h13;
   localparam logic [5:0] OP_TEST_WR = 6'h15;
   localparam logic [5:0] OP_GX_WR = 6'h18;
   localparam logic [5:0] OP_GR_WR = 6'h1A;
   localparam logic [5:0] OP_BAL_WR = 6'h1E;
   localparam logic [5:0] OP_BAL_RD = 6'h1F;
   localparam logic [5:0] OP_EPG_WR = 6'h24;
   localparam logic [5:0] OP_ELT_WR = 6'h26;
   localparam logic [5:0] OP_OPF2_WR = 6'h2C;
   // Test word bit positions
   localparam int TB_TSA_LOOP = 0;
   localparam int TB_ANA_LOOP = 1;
   localparam int TB_HPF_BYP = 2;
   localparam int TB_CUT_RX = 3;
   localparam int TB_CUT_TX = 4;
   // Operating functions word bit positions
   localparam int OB_CHOP_FAST = 0;
   localparam int OB_MU_LAW = 1;
   localparam int AB_ADAPT_EN = 0;
   localparam logic [4:0] SCALE_LOOP = 5'h10;
   // Coefficient arithmetic
   localparam int CSD_VAL_W = 24;
   localparam int CSD_FRAC = 20;
   localparam int FIR_TERMS = 3;
   localparam int IIR_TERMS = 4;
   localparam int NUM_TAPS = 8;
   localparam int BAL_IIR_IDX = 8;
   localparam int ADAPT_STEP_SH = 12;
   localparam logic [11:0] BAL_VALID_TAP = 12'h02AF;
   localparam logic [15:0] BAL_VALID_IIR = 16'h0A80;
   localparam logic [15:0] COEF_RESET = 16'h0000;
   localparam int LINE_IO_N = 5;
   localparam int PIN5_BIT = 4;
   // Chopper timing
   localparam int CLK_HZ = 100_000_000;
   localparam int CHOP_SLOW_HZ = 256_000;
   localparam int CHOP_FAST_HZ = 292_571;
   localparam int CHOP_SLOW_HALF = CLK_HZ / (2 * CHOP_SLOW_HZ);
   localparam int CHOP_FAST_HALF = CLK_HZ / (2 * CHOP_FAST_HZ);
   localparam int CHOP_CNT_W = 9;
endpackage

// file: design/vcf_host_if.sv
`timescale 1ns/1ns
`default_nettype none
interface vcf_host_if;
   import vcf_pkg::*;
   logic cmd_valid;
   logic cmd_ready;
   logic [OP_W-1:0] cmd_op;
   logic [IDX_W-1:0] cmd_idx;
   logic [DATA_W-1:0] cmd_data;
   logic rsp_valid;
   logic [DATA_W-1:0] rsp_data;
   modport dev (input cmd_valid, cmd_op, cmd_idx, cmd_data,
      output cmd_ready, rsp_valid, rsp_data);
   modport host (output cmd_valid, cmd_op, cmd_idx, cmd_data,
      input cmd_ready, rsp_valid, rsp_data);
endinterface // vcf_host_if
`default_nettype wire

// file: design/vcf_channel_dev.sv
`timescale 1ns/1ns
`default_nettype none
module vcf_channel_dev
   import vcf_pkg::*;
#(
   parameter int NUM_IO = LINE_IO_N
) (
   input wire logic clock_i,
   input wire logic reset_i,
   vcf_host_if.dev ctl,
   input wire logic frame_tick_i,
   input wire logic chan_active_i,
   input wire logic other_chan_active_i,
   input wire logic signed [15:0] analog_input_pad_i,
   output logic signed [15:0] analog_output_pad_o,
   input wire logic [7:0] pcm_receive_input_i,
   output logic [7:0] pcm_transmit_output_o,
   output logic chopper_clock_output_o,
   input wire logic [NUM_IO-1:0] line_io_i,
   output logic [NUM_IO-1:0] line_io_o,
   output logic [NUM_IO-1:0] line_io_oe_o
);
   if (NUM_IO < 1 || NUM_IO > LINE_IO_N) begin : g_chk
      $error("NUM_IO out of range");
   end
   localparam logic signed [CSD_VAL_W-1:0] CSD_ONE = 24'sh10_0000;
   localparam logic signed [CSD_VAL_W-1:0] STEP = CSD_ONE >>> ADAPT_STEP_SH;
   typedef logic signed [CSD_VAL_W-1:0] vcf_coef_t;

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers
   // Chain of terms, each shift relative to the previous one
   function automatic vcf_coef_t csd_eval(input logic [15:0] w, input int n);
      vcf_coef_t acc;
      logic neg;
      int sh;
      logic [3:0] nib;
      acc = '0;
      neg = 1'b0;
      sh = 0;
      for (int k = 0; k < 4; k++) begin
         if (k < n) begin
            nib = w[4*(n-1-k) +: 4];
            neg = neg ^ nib[3];
            sh = sh + int'(nib[2:0]);
            acc = neg ? acc - (CSD_ONE >>> sh) : acc + (CSD_ONE >>> sh);
         end
      end
      return acc;
   endfunction
   // Greedy re-coding of an adapted tap; truncates, but overshoots a remainder below the reach of a 3-bit shift
   function automatic logic [11:0] csd_enc3(input vcf_coef_t v);
      vcf_coef_t rem;
      logic [CSD_VAL_W-1:0] mag;
      logic neg, pneg;
      int prev, s, p;
      logic [11:0] w;
      rem = v;
      prev = 0;
      pneg = 1'b0;
      w = '0;
      for (int k = 0; k < FIR_TERMS; k++) begin
         neg = rem[CSD_VAL_W-1];
         mag = neg ? unsigned'(-rem) : unsigned'(rem);
         p = -1;
         for (int b = 0; b < CSD_VAL_W; b++) if (mag[b]) p = b;
         s = (p < 0) ? prev + 7 : CSD_FRAC - p;
         if (s < prev) s = prev;
         if (s > prev + 7) s = prev + 7;
         if (p < 0) neg = pneg;
         w[4*(FIR_TERMS-1-k) +: 4] = {neg ^ pneg, 3'(s - prev)};
         rem = neg ? rem + (CSD_ONE >>> s) : rem - (CSD_ONE >>> s);
         prev = s;
         pneg = neg;
      end
      return w;
   endfunction
   function automatic logic signed [15:0] mulq(input logic signed [15:0] x,
      input vcf_coef_t c);
      logic signed [CSD_VAL_W+15:0] p;
      p = x * c;
      p = p >>> CSD_FRAC;
      if (p[CSD_VAL_W+15:15] != {(CSD_VAL_W+1){p[15]}})
         return p[CSD_VAL_W+15] ? 16'sh8000 : 16'sh7FFF;
      return p[15:0];
   endfunction
   function automatic logic signed [15:0] abs16(input logic signed [15:0] x);
      if (x == 16'sh8000) return 16'sh7FFF;
      return x[15] ? -x : x;
   endfunction
   function automatic logic [7:0] alaw_enc(input logic signed [15:0] x);
      logic [15:0] a;
      logic [11:0] m;
      logic [2:0] seg;
      a = abs16(x);
      m = a[14:3];
      seg = 3'h0;
      for (int b = 5; b < 12; b++) if (m[b]) seg = 3'(b - 4);
      return {~x[15], seg, 4'(m >> ((seg == 3'h0) ? 3'h1 : seg))} ^ 8'h55;
   endfunction
   function automatic logic signed [15:0] alaw_dec(input logic [7:0] code);
      logic [7:0] c;
      logic [14:0] m;
      c = code ^ 8'h55;
      m = (c[6:4] == 3'h0) ? {10'h000, c[3:0], 1'b1} :
         (15'({1'b1, c[3:0], 1'b1}) << (c[6:4] - 3'h1));
      m = m << 3;
      return c[7] ? $signed({1'b0, m}) : -$signed({1'b0, m});
   endfunction
   function automatic logic [7:0] ulaw_enc(input logic signed [15:0] x);
      logic [15:0] a;
      logic [13:0] b;
      logic [2:0] seg;
      logic [6:0] n;
      a = abs16(x);
      b = 14'(a[15:2]) + 14'h0021;
      if (b > 14'h1FFF) b = 14'h1FFF;
      seg = 3'h0;
      for (int k = 6; k < 13; k++) if (b[k]) seg = 3'(k - 5);
      n = {seg, 4'(b >> (4'(seg) + 4'h1))};
      return x[15] ? 8'h7F - {1'b0, n} : 8'hFF - {1'b0, n};
   endfunction
   function automatic logic signed [15:0] ulaw_dec(input logic [7:0] code);
      logic [6:0] n;
      logic [13:0] m;
      n = code[7] ? 7'(8'hFF - code) : 7'(8'h7F - code);
      m = 14'({n[3:0], 1'b1} + 6'h20 + 6'h00) << n[6:4];
      m = m - 14'h0021;
      return code[7] ? $signed({m, 2'b00}) : -$signed({m, 2'b00});
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Programmed state
   logic [15:0] gx_reg, gr_reg, epg_reg, b8_reg;
   logic [7:0] elt_reg;
   logic [4:0] scale_reg, test_reg;
   logic [1:0] opf_reg;
   logic adapt_reg;
   logic [NUM_IO-1:0] io_out_reg, io_dir_reg, io_s1_reg, io_s2_reg;
   vcf_coef_t tap_reg [NUM_TAPS];
   logic signed [15:0] xh_reg [NUM_TAPS];
   logic signed [15:0] iir_reg, dac_reg;
   logic signed [23:0] dc_reg;
   logic [7:0] pcm_tx_reg;
   logic rsp_valid_reg;
   logic [15:0] rsp_data_reg;
   logic chop_reg;
   logic [CHOP_CNT_W-1:0] chop_cnt_reg;

   // Command decode
   wire logic take = ctl.cmd_valid;
   wire logic [3:0] idx = ctl.cmd_idx;
   wire logic wr_bal = take && ctl.cmd_op == OP_BAL_WR;
   wire logic [NUM_IO-1:0] io_state = (io_dir_reg & io_out_reg) | (~io_dir_reg & io_s2_reg);
   assign ctl.cmd_ready = 1'b1;
   assign ctl.rsp_valid = rsp_valid_reg;
   assign ctl.rsp_data = rsp_data_reg;

   ////////////////////////////////////////////////////////////////////////
   // Voice path
   wire logic mu = opf_reg[OB_MU_LAW];
   wire logic signed [15:0] rx_lin = mu ? ulaw_dec(pcm_receive_input_i) :
      alaw_dec(pcm_receive_input_i);
   wire logic signed [15:0] rx_g = mulq(rx_lin, csd_eval(gr_reg, IIR_TERMS));
   // Converter loop feeds the output word back; the pad keeps it too
   wire logic scale_loop = scale_reg == SCALE_LOOP;
   wire logic signed [15:0] adc = scale_loop ? dac_reg : analog_input_pad_i;
   wire logic signed [15:0] hp = test_reg[TB_HPF_BYP] ? adc : adc - dc_reg[23:8];
   wire vcf_coef_t gx_val = CSD_ONE + csd_eval(gx_reg, IIR_TERMS);
   wire vcf_coef_t epg_val = CSD_ONE + csd_eval(epg_reg, IIR_TERMS);
   wire vcf_coef_t elt_val = csd_eval({8'h00, elt_reg}, 2);
   wire vcf_coef_t b8_val = csd_eval(b8_reg, IIR_TERMS);
   logic signed [15:0] xv [NUM_TAPS];
   logic signed [15:0] iir_w, bout;
   logic signed [19:0] acc;
   // Balance filter: seven plain taps plus one recursive section
   always_comb begin
      acc = '0;
      xv[0] = rx_g;
      for (int k = 1; k < NUM_TAPS; k++) xv[k] = xh_reg[k-1];
      for (int k = 0; k < NUM_TAPS - 1; k++) acc = acc + 20'(mulq(xv[k], tap_reg[k]));
      iir_w = mulq(xv[NUM_TAPS-1], tap_reg[NUM_TAPS-1]) + mulq(iir_reg, b8_val);
      acc = acc + 20'(iir_w);
      if (acc[19:15] != {5{acc[15]}}) bout = acc[19] ? 16'sh8000 : 16'sh7FFF;
      else bout = acc[15:0];
   end
   wire logic signed [16:0] e_w = 17'(hp) - 17'(bout);
   wire logic signed [15:0] err = (e_w[16:15] == 2'b01) ? 16'sh7FFF :
      (e_w[16:15] == 2'b10) ? 16'sh8000 : e_w[15:0];
   wire logic signed [15:0] tx_g = mulq(err, gx_val);
   wire logic near_end = abs16(hp) > mulq(abs16(rx_g), epg_val);
   wire logic loss_met = abs16(err) <= mulq(abs16(hp), elt_val);
   wire logic adapt_go = frame_tick_i && adapt_reg && !near_end && !loss_met;
   wire logic [7:0] tx_code = test_reg[TB_CUT_TX] ? (mu ? ulaw_enc(16'sh0000) :
      alaw_enc(16'sh0000)) : (mu ? ulaw_enc(tx_g) : alaw_enc(tx_g));
   wire logic signed [15:0] dac_next = test_reg[TB_ANA_LOOP] ? hp :
      (test_reg[TB_CUT_RX] ? 16'sh0000 : rx_g);

   ////////////////////////////////////////////////////////////////////////
   // Control registers written by commands
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         gx_reg <= COEF_RESET;
         gr_reg <= COEF_RESET;
         epg_reg <= COEF_RESET;
         elt_reg <= 8'h00;
         scale_reg <= 5'h00;
         test_reg <= 5'h00;
         opf_reg <= 2'h0;
         adapt_reg <= 1'b0;
         io_out_reg <= '0;
         io_dir_reg <= '0;
         b8_reg <= COEF_RESET;
      end else if (take) begin
         if (ctl.cmd_op == OP_GX_WR) gx_reg <= ctl.cmd_data;
         else if (ctl.cmd_op == OP_GR_WR) gr_reg <= ctl.cmd_data;
         else if (ctl.cmd_op == OP_EPG_WR) epg_reg <= ctl.cmd_data;
         else if (ctl.cmd_op == OP_ELT_WR) elt_reg <= ctl.cmd_data[7:0];
         else if (ctl.cmd_op == OP_SCALE_WR) scale_reg <= ctl.cmd_data[4:0];
         else if (ctl.cmd_op == OP_TEST_WR) test_reg <= ctl.cmd_data[4:0];
         else if (ctl.cmd_op == OP_OPF2_WR) opf_reg <= ctl.cmd_data[1:0];
         else if (ctl.cmd_op == OP_ADAPT_WR) adapt_reg <= ctl.cmd_data[AB_ADAPT_EN];
         else if (ctl.cmd_op == OP_IO_WR) io_out_reg <= ctl.cmd_data[NUM_IO-1:0];
         else if (ctl.cmd_op == OP_DIR_WR) io_dir_reg <= ctl.cmd_data[NUM_IO-1:0];
         else if (ctl.cmd_op == OP_BAL_WR && idx == 4'(BAL_IIR_IDX)) b8_reg <= ctl.cmd_data;
      end
   end
   // Taps: a host write wins over an adaptation step in the same cycle
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         for (int k = 0; k < NUM_TAPS; k++) tap_reg[k] <= '0;
      end else begin
         for (int k = 0; k < NUM_TAPS; k++) begin
            if (wr_bal && idx == 4'(k)) tap_reg[k] <= csd_eval(ctl.cmd_data, FIR_TERMS);
            else if (adapt_go) tap_reg[k] <= (err[15] ^ xv[k][15]) ?
               tap_reg[k] - STEP : tap_reg[k] + STEP;
         end
      end
   end
   // Answers to read commands, one cycle after the command
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 16'h0000;
      end else begin
         rsp_valid_reg <= take && (ctl.cmd_op == OP_BAL_RD || ctl.cmd_op == OP_IO_RD);
         if (take && ctl.cmd_op == OP_IO_RD) rsp_data_reg <= 16'(io_state);
         else if (take && ctl.cmd_op == OP_BAL_RD) rsp_data_reg <= (idx == 4'(BAL_IIR_IDX)) ?
            b8_reg : {4'h0, csd_enc3(tap_reg[idx[2:0]])};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-frame sample state
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         for (int k = 0; k < NUM_TAPS; k++) xh_reg[k] <= 16'sh0000;
         iir_reg <= 16'sh0000;
         dac_reg <= 16'sh0000;
         dc_reg <= 24'sh00_0000;
         pcm_tx_reg <= 8'h00;
      end else if (frame_tick_i) begin
         for (int k = 1; k < NUM_TAPS; k++) xh_reg[k] <= xh_reg[k-1];
         xh_reg[0] <= rx_g;
         iir_reg <= iir_w;
         dac_reg <= dac_next;
         dc_reg <= dc_reg + 24'(hp);
         pcm_tx_reg <= test_reg[TB_TSA_LOOP] ? pcm_receive_input_i : tx_code;
      end
   end
   assign analog_output_pad_o = dac_reg;
   assign pcm_transmit_output_o = pcm_tx_reg;

   ////////////////////////////////////////////////////////////////////////
   // Line pins and chopper
   // Pin levels come from outside; two stages before any reader
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         io_s1_reg <= '0;
         io_s2_reg <= '0;
      end else begin
         io_s1_reg <= line_io_i;
         io_s2_reg <= io_s1_reg;
      end
   end
   assign line_io_o = io_out_reg;
   assign line_io_oe_o = io_dir_reg;
   wire logic chop_run = chan_active_i || other_chan_active_i;
   wire logic [CHOP_CNT_W-1:0] chop_half = opf_reg[OB_CHOP_FAST] ?
      CHOP_CNT_W'(CHOP_FAST_HALF - 1) : CHOP_CNT_W'(CHOP_SLOW_HALF - 1);
   // Parked high when idle so the regulator sees no stray edge
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         chop_reg <= 1'b1;
         chop_cnt_reg <= '0;
      end else if (!chop_run) begin
         chop_reg <= 1'b1;
         chop_cnt_reg <= '0;
      end else if (chop_cnt_reg >= chop_half) begin
         chop_reg <= ~chop_reg;
         chop_cnt_reg <= '0;
      end else begin
         chop_cnt_reg <= chop_cnt_reg + 1'b1;
      end
   end
   assign chopper_clock_output_o = chop_reg;
endmodule // vcf_channel_dev
`default_nettype wire

// file: design/vcf_host_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module vcf_host_ctrl
   import vcf_pkg::*;
#(
   parameter bit PIN5_OUT_ONLY = 1'b1
) (
   input wire logic clock_i,
   input wire logic reset_i,
   vcf_host_if.host ctl,
   input wire logic req_valid_i,
   input wire logic [OP_W-1:0] req_op_i,
   input wire logic [IDX_W-1:0] req_idx_i,
   input wire logic [DATA_W-1:0] req_data_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [DATA_W-1:0] rsp_data_o
);
   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_PRE = 4'b0010,
      HS_MAIN = 4'b0100,
      HS_WAIT = 4'b1000
   } vcf_hstate_e;
   vcf_hstate_e state_reg, state_next;
   logic [OP_W-1:0] op_reg;
   logic [IDX_W-1:0] idx_reg, cnt_reg;
   logic [DATA_W-1:0] data_reg;
   logic pre_dir_reg, bal_ok_reg, dir_sent_reg, rsp_valid_reg;
   logic [LINE_IO_N-1:0] dir_reg;
   logic [DATA_W-1:0] rsp_data_reg;

   // Preamble needs: valid balance set, or direction of the fifth pin
   wire logic [LINE_IO_N-1:0] dir_force = PIN5_OUT_ONLY ? 5'h10 : 5'h00;
   wire logic need_bal = req_op_i == OP_ADAPT_WR && req_data_i[AB_ADAPT_EN] && !bal_ok_reg;
   wire logic need_dir = PIN5_OUT_ONLY && req_op_i == OP_IO_WR && !dir_sent_reg;
   wire logic is_read = op_reg == OP_BAL_RD || op_reg == OP_IO_RD;
   wire logic sent = ctl.cmd_valid && ctl.cmd_ready;
   wire logic bal_last = cnt_reg == IDX_W'(BAL_IIR_IDX);
   wire logic [DATA_W-1:0] bal_word = bal_last ? BAL_VALID_IIR : {4'h0, BAL_VALID_TAP};

   // Command word driven toward the device
   assign ctl.cmd_valid = state_reg == HS_PRE || state_reg == HS_MAIN;
   assign ctl.cmd_op = (state_reg == HS_PRE) ? (pre_dir_reg ? OP_DIR_WR : OP_BAL_WR) : op_reg;
   assign ctl.cmd_idx = (state_reg == HS_PRE) ? cnt_reg : idx_reg;
   assign ctl.cmd_data = (state_reg == HS_PRE) ?
      (pre_dir_reg ? 16'({dir_reg | dir_force}) : bal_word) :
      ((op_reg == OP_DIR_WR) ? data_reg | 16'(dir_force) : data_reg);
   assign req_ready_o = state_reg == HS_IDLE;
   assign rsp_valid_o = rsp_valid_reg;
   assign rsp_data_o = rsp_data_reg;

   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         HS_IDLE: begin
            if (req_valid_i) state_next = (need_bal || need_dir) ? HS_PRE : HS_MAIN;
         end
         HS_PRE: begin
            if (sent && (pre_dir_reg || bal_last)) state_next = HS_MAIN;
         end
         HS_MAIN: begin
            if (sent) state_next = is_read ? HS_WAIT : HS_IDLE;
         end
         HS_WAIT: begin
            if (ctl.rsp_valid) state_next = HS_IDLE;
         end
         default: state_next = HS_IDLE;
      endcase
   end
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= HS_IDLE;
         op_reg <= '0;
         idx_reg <= '0;
         data_reg <= '0;
         cnt_reg <= '0;
         pre_dir_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == HS_IDLE && req_valid_i) begin
            op_reg <= req_op_i;
            idx_reg <= req_idx_i;
            data_reg <= req_data_i;
            cnt_reg <= '0;
            pre_dir_reg <= !need_bal;
         end else if (state_reg == HS_PRE && sent && !pre_dir_reg) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
   // Bookkeeping of what the device already holds
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         bal_ok_reg <= 1'b0;
         dir_sent_reg <= 1'b0;
         dir_reg <= '0;
      end else if (sent) begin
         if (state_reg == HS_PRE && !pre_dir_reg && bal_last) bal_ok_reg <= 1'b1;
         else if (state_reg == HS_PRE && pre_dir_reg) dir_sent_reg <= 1'b1;
         else if (state_reg == HS_MAIN && op_reg == OP_BAL_WR) bal_ok_reg <= 1'b0;
         else if (state_reg == HS_MAIN && op_reg == OP_DIR_WR) begin
            dir_sent_reg <= 1'b1;
            dir_reg <= data_reg[LINE_IO_N-1:0] | dir_force;
         end
      end
   end
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= '0;
      end else begin
         rsp_valid_reg <= state_reg == HS_WAIT && ctl.rsp_valid;
         if (state_reg == HS_WAIT && ctl.rsp_valid) rsp_data_reg <= ctl.rsp_data;
      end
   end
endmodule // vcf_host_ctrl
`default_nettype wire

// file: bench/vcf_checker.sv
`timescale 1ns/1ns
`default_nettype none
module vcf_checker
   import vcf_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [OP_W-1:0] cmd_op,
   input wire logic [IDX_W-1:0] cmd_idx,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic rsp_valid,
   input wire logic [DATA_W-1:0] rsp_data
);
   logic dir_seen_reg;
   // Pin writes ahead of any direction write would float the fifth pin
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) dir_seen_reg <= 1'b0;
      else if (cmd_valid && cmd_op == OP_DIR_WR) dir_seen_reg <= 1'b1;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   sequence s_read_req;
      cmd_valid && (cmd_op == OP_IO_RD || cmd_op == OP_BAL_RD);
   endsequence
   ////////////////////////////////////////////////////////////
   chk_read_answer: assert property (s_read_req |=> rsp_valid)
      else $error("read not answered");
   chk_write_silent: assert property (cmd_valid && cmd_op == OP_IO_WR |=> !rsp_valid)
      else $error("write answered");
   chk_answer_cause: assert property (rsp_valid |-> $past(cmd_valid) &&
      ($past(cmd_op) == OP_IO_RD || $past(cmd_op) == OP_BAL_RD)) else $error("stray answer");
   chk_answer_pulse: assert property (s_read_req ##1 rsp_valid |=> !rsp_valid)
      else $error("answer too long");
   chk_data_holds: assert property ($changed(rsp_data) |-> rsp_valid)
      else $error("answer data moved");
   chk_tap_three: assert property (cmd_valid && cmd_op == OP_BAL_RD && cmd_idx != 4'h8
      |=> rsp_data[15:12] == 4'h0) else $error("tap has four terms");
   chk_dir_first: assert property (cmd_valid && cmd_op == OP_IO_WR |-> dir_seen_reg)
      else $error("pin write before direction");
   chk_pin5_out: assert property (cmd_valid && cmd_op == OP_DIR_WR |-> cmd_data[PIN5_BIT])
      else $error("fifth pin not output");
endmodule // vcf_checker
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import vcf_pkg::*;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic frame_tick_i = 1'b0;
   logic act_a = 1'b0, act_b = 1'b0, req_valid_i = 1'b0, req_ready_o, rsp_valid_o, chop;
   logic [OP_W-1:0] req_op_i = '0;
   logic [IDX_W-1:0] req_idx_i = '0;
   logic [DATA_W-1:0] req_data_i = '0, rsp_data_o;
   logic signed [15:0] ana_in = '0, ana_out;
   logic [7:0] pcm_rx = '0, pcm_tx;
   logic [4:0] pin_drv = '0, pins_out, pins_oe;
   wire [4:0] pins_in;
   int err_count = 0, compares = 0;
   // Pin level: device wins where it drives
   assign pins_in = (pins_out & pins_oe) | (pin_drv & ~pins_oe);
   always #5 clock_i = ~clock_i;
   vcf_host_if hif();
   vcf_channel_dev i_vcf_channel_dev(.clock_i(clock_i), .reset_i(reset_i), .ctl(hif),
      .frame_tick_i(frame_tick_i), .chan_active_i(act_a), .other_chan_active_i(act_b),
      .analog_input_pad_i(ana_in), .analog_output_pad_o(ana_out), .pcm_receive_input_i(pcm_rx),
      .pcm_transmit_output_o(pcm_tx), .chopper_clock_output_o(chop), .line_io_i(pins_in),
      .line_io_o(pins_out), .line_io_oe_o(pins_oe));
   vcf_host_ctrl i_vcf_host_ctrl(.clock_i(clock_i), .reset_i(reset_i), .ctl(hif),
      .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_idx_i(req_idx_i),
      .req_data_i(req_data_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o));
   vcf_checker i_vcf_checker(.clock_i(clock_i), .reset_i(reset_i), .cmd_valid(hif.cmd_valid),
      .cmd_ready(hif.cmd_ready), .cmd_op(hif.cmd_op), .cmd_idx(hif.cmd_idx),
      .cmd_data(hif.cmd_data), .rsp_valid(hif.rsp_valid), .rsp_data(hif.rsp_data));
   ////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Request held until ready is seen at the edge that takes it
   task req(input logic [5:0] op, input logic [3:0] idx, input logic [15:0] data);
      int n;
      n = 0;
      @(posedge clock_i);
      req_valid_i <= 1'b1;
      req_op_i <= op;
      req_idx_i <= idx;
      req_data_i <= data;
      do begin @(negedge clock_i); n++; end while (req_ready_o !== 1'b1 && n < 50);
      if (req_ready_o !== 1'b1) err_count++;
      @(posedge clock_i);
      req_valid_i <= 1'b0;
   endtask
   task rd(input logic [5:0] op, input logic [3:0] idx, output logic [15:0] d);
      int n;
      n = 0;
      req(op, idx, 16'h0000);
      do begin @(negedge clock_i); n++; end while (rsp_valid_o !== 1'b1 && n < 50);
      d = rsp_data_o;
   endtask
   task frames(input int k, input logic [7:0] rx, input logic [15:0] ain);
      @(posedge clock_i);
      pcm_rx <= rx;
      ana_in <= ain;
      repeat (k) begin
         @(posedge clock_i) frame_tick_i <= 1'b1;
         @(posedge clock_i) frame_tick_i <= 1'b0;
         repeat (3) @(posedge clock_i);
      end
      @(negedge clock_i);
   endtask
   // Length of one fresh low phase, started after a full transition
   task low_len(output int n);
      int k;
      k = 0;
      while (chop !== 1'b0 && k < 900) begin @(negedge clock_i); k++; end
      while (chop !== 1'b1 && k < 900) begin @(negedge clock_i); k++; end
      while (chop !== 1'b0 && k < 900) begin @(negedge clock_i); k++; end
      n = 0;
      while (chop === 1'b0 && n < 900) begin @(negedge clock_i); n++; end
   endtask
   ////////////////////////////////////////////////////////////
   task t_chop;
      int n;
      n = 0;
      repeat (400) begin @(negedge clock_i); if (chop !== 1'b1) n++; end
      check(n, 32'h0000_0000);
      @(posedge clock_i) act_a <= 1'b1;
      low_len(n);
      check(n, 32'h0000_00c3);
      req(OP_OPF2_WR, 4'h0, 16'h0001);
      act_a <= 1'b0;
      act_b <= 1'b1;
      low_len(n);
      check(n, 32'h0000_00aa);
      $display("chopper test done");
   endtask
   task t_tsa;
      req(OP_TEST_WR, 4'h0, 16'h0001);
      frames(1, 8'ha5, 16'h0000);
      check(pcm_tx, 8'ha5);
      frames(1, 8'h3c, 16'h0000);
      check(pcm_tx, 8'h3c);
      req(OP_TEST_WR, 4'h0, 16'h0000);
      $display("loopback test done");
   endtask
   // Sign bit for both laws; step into each polarity
   task t_sign;
      for (int law = 0; law < 2; law++) begin
         req(OP_OPF2_WR, 4'h0, law ? 16'h0002 : 16'h0000);
         frames(3, 8'h00, 16'h03e8);
         check(pcm_tx[7], 1'b1);
         frames(3, 8'h00, 16'hfc18);
         check(pcm_tx[7], 1'b0);
      end
      $display("sign test done");
   endtask
   task t_pins;
      logic [15:0] d;
      @(posedge clock_i) pin_drv <= 5'h0c;
      req(OP_IO_WR, 4'h0, 16'h0015);
      req(OP_DIR_WR, 4'h0, 16'h0003);
      rd(OP_IO_RD, 4'h0, d);
      check(pins_oe, 5'h13);
      check(pins_out, 5'h15);
      check(d, 16'h001d);
      $display("pin test done");
   endtask
   task t_loop;
      req(OP_TEST_WR, 4'h0, 16'h0016);
      frames(1, 8'h00, 16'h1234);
      check(ana_out, 16'h1234);
      check(pcm_tx, 8'hff);
      req(OP_SCALE_WR, 4'h0, 16'h0010);
      frames(1, 8'h00, 16'h0000);
      check(ana_out, 16'h1234);
      $display("test modes done");
   endtask
   // Adapt from the default set, then freeze and read back
   task t_bal;
      logic [15:0] a, b;
      req(OP_ADAPT_WR, 4'h0, 16'h0001);
      frames(20, 8'h55, 16'h0400);
      req(OP_ADAPT_WR, 4'h0, 16'h0000);
      rd(OP_BAL_RD, 4'h8, a);
      check(a, 16'h0a80);
      rd(OP_BAL_RD, 4'h0, a);
      frames(10, 8'h55, 16'h0400);
      rd(OP_BAL_RD, 4'h0, b);
      check(b, a);
      $display("balance test done");
   endtask
   initial begin
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      t_chop;
      t_tsa;
      t_sign;
      t_pins;
      t_loop;
      t_bal;
      close_out;
   end
   // Watchdog well beyond the expected run
   initial begin
      #400000;
      err_count++;
      close_out;
   end
endmodule // testbench
`default_nettype wire
